// ==== hdl/lin_wake_pkg.sv ====
/*
  Shared constants for the single-wire bus wake, fault and mode control.
  Assumes a 40 MHz system clock; times are kept in their own unit and
  converted to cycles here.
*/
package lin_wake_pkg;

  localparam int unsigned CLK_HZ = 40000000;

  // Transceiver mode codes
  localparam logic [1:0] TRX_OFF    = 2'h0;
  localparam logic [1:0] TRX_WAKE   = 2'h1;
  localparam logic [1:0] TRX_RXONLY = 2'h2;
  localparam logic [1:0] TRX_NORMAL = 2'h3;
  localparam logic [1:0] TRX_RESET  = 2'h0;

  // Device modes, Gray coded along normal-stop-sleep-failsafe-restart
  typedef enum logic [2:0] {
    DEV_NORMAL   = 3'h0,
    DEV_STOP     = 3'h1,
    DEV_SLEEP    = 3'h3,
    DEV_FAILSAFE = 3'h2,
    DEV_RESTART  = 3'h6
  } dev_mode_t;

  // Wake filter: dominant must last longer than the least filter time
  localparam int unsigned WAKE_FILTER_MIN_US = 30;
  localparam int unsigned WAKE_FILTER_MAX_US = 150;
  localparam int unsigned WAKE_FILTER_CYC =
    (WAKE_FILTER_MIN_US * (CLK_HZ / 1000000));

  // Dominant timeouts, typical figure
  localparam int unsigned TX_TIMEOUT_MS  = 20;
  localparam int unsigned BUS_TIMEOUT_MS = 20;
  localparam int unsigned TX_TIMEOUT_CYC  = TX_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned BUS_TIMEOUT_CYC = BUS_TIMEOUT_MS * (CLK_HZ / 1000);

  localparam int unsigned TIMER_W = 20;
  localparam int unsigned WAKE_W  = 12;

endpackage

// ==== hdl/lin_wake_filter.sv ====
/*
  Bus wake filter: a dominant phase longer than the filter count, closed
  by a dominant-to-recessive edge, gives a one-cycle wake pulse.
  Assumes a synchronised bus level on the same clock.
*/
`timescale 1ns/100ps
module lin_wake_filter #(
  parameter int unsigned FILTER_CYC = lin_wake_pkg::WAKE_FILTER_CYC
) (
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  input  wire logic clk_en_in,
  // Control
  input  wire logic armed_in,
  input  wire logic bus_dominant_in,
  // Event
  output logic      wake_pulse_out
);

  logic [lin_wake_pkg::WAKE_W-1:0] dom_cnt_r;
  logic                            dom_prev_r;
  logic                            long_enough;
  logic                            rise_edge;

  assign long_enough = (dom_cnt_r >= lin_wake_pkg::WAKE_W'(FILTER_CYC));
  assign rise_edge   = dom_prev_r && !bus_dominant_in;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      dom_cnt_r      <= '0;
      dom_prev_r     <= 1'b0;
      wake_pulse_out <= 1'b0;
    end else if (clk_en_in) begin
      dom_prev_r     <= bus_dominant_in;
      wake_pulse_out <= armed_in && rise_edge && long_enough;
      if (!bus_dominant_in || !armed_in) begin
        dom_cnt_r <= '0;
      end else if (!long_enough) begin
        dom_cnt_r <= dom_cnt_r + 1'b1;
      end
    end
  end

endmodule

// ==== hdl/lin_wake_ctrl.sv ====
/*
  Single-wire bus transceiver control: device and transceiver modes, bus
  wake signalling and rearming, dominant timeouts, fault flag,
  undervoltage suspension and slope selection.
  Assumes configuration words are presented while chip_select_n_in is low
  and committed on its rising edge; host strobes are on clock_in.
*/
`timescale 1ns/100ps
// Behaviour
// - Fail-safe forces wake mode; config may pick it in stop, sleep, restart, normal
// - Wake needs dominant longer than filter time, taken on rising edge
// - Bus wake drives receive output low until transceiver mode changes
// - Wake in stop or normal keeps mode, asserts interrupt, records status
// - Wake in sleep or fail-safe goes restart then normal, no interrupt
// - After wake the mode field still reads wake code, receive stays low
// - Entering stop, sleep or fail-safe rearms wake detection
// - Watchdog-on-wake bit enables watchdog on bus wake in stop
// - Transmit dominant too long disables driver, bus stays recessive
// - Transmit timeout sets the transceiver fault flag
// - Driver re-enabled once transmit input is recessive again
// - Bus dominant too long in normal or receive-only sets fault flag
// - Supply undervoltage disables driver and receiver, config kept
// - Low-slope bit, normal mode only, applied at chip select release, output held off while flash-speed bit set
// - Flash-speed bit, normal mode only, applied at chip select release
// - Transmit timeout is 20 ms
// - Bus dominant timeout is 20 ms
module lin_wake_ctrl #(
  parameter int unsigned TX_TO_CYC  = lin_wake_pkg::TX_TIMEOUT_CYC,
  parameter int unsigned BUS_TO_CYC = lin_wake_pkg::BUS_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  input  wire logic       clk_en_in,
  // Configuration port
  input  wire logic       chip_select_n_in,
  input  wire logic [1:0] trx_mode_in,
  input  wire logic [2:0] dev_mode_in,
  input  wire logic       dev_mode_wr_in,
  input  wire logic       low_slope_select_in,
  input  wire logic       flash_speed_in,
  input  wire logic       watchdog_on_bus_wake_en_in,
  input  wire logic       watchdog_en_in,
  input  wire logic       fault_clear_in,
  input  wire logic       wake_status_clear_in,
  input  wire logic       interrupt_clear_in,
  // Device events
  input  wire logic       fail_safe_in,
  input  wire logic       restart_done_in,
  // Pins and analog
  input  wire logic       bus_transmit_in,
  input  wire logic       bus_level_in,
  input  wire logic       bus_supply_uv_in,
  // Outputs
  output logic            bus_receive_out,
  output logic            bus_drive_dom_out,
  output logic            driver_en_out,
  output logic            receiver_en_out,
  output logic            interrupt_out_n,
  output logic            wake_status_reg_out,
  output logic            fault_flag_out,
  output logic            watchdog_en_out,
  output logic            low_slope_out,
  output logic            flash_speed_out,
  output logic [1:0]      trx_mode_out,
  output logic [2:0]      dev_mode_out
);

  // Three-stage synchronisers for pins: cs, txd, bus, uv
  logic [3:0] s1_r, s2_r, s3_r, stab_r;
  logic [3:0] raw;
  assign raw = {bus_supply_uv_in, bus_level_in, bus_transmit_in, chip_select_n_in};

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      s1_r   <= 4'hf;
      s2_r   <= 4'hf;
      s3_r   <= 4'hf;
      stab_r <= 4'hf;
    end else if (clk_en_in) begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < 4; i++) begin
        if (s2_r[i] == s3_r[i]) stab_r[i] <= s3_r[i];
      end
    end
  end

  logic cs_n_s, tx_dom, bus_dom, uv;
  logic cs_prev_r;
  logic commit;
  assign cs_n_s  = stab_r[0];
  assign tx_dom  = !stab_r[1];
  assign bus_dom = !stab_r[2];
  assign uv      = stab_r[3];
  assign commit  = cs_n_s && !cs_prev_r;

  // State
  lin_wake_pkg::dev_mode_t dev_r, dev_nxt;
  logic [1:0] trx_r, trx_nxt;
  logic armed_r, woken_r, tx_block_r, fault_r, wdg_r, int_r, wkst_r;
  logic lsm_r, flash_r;
  logic [lin_wake_pkg::TIMER_W-1:0] tx_cnt_r, bus_cnt_r;
  logic wake;

  wire in_normal  = (dev_r == lin_wake_pkg::DEV_NORMAL);
  wire in_stop    = (dev_r == lin_wake_pkg::DEV_STOP);
  wire wake_mode  = (trx_r == lin_wake_pkg::TRX_WAKE);
  wire trx_active = (trx_r == lin_wake_pkg::TRX_NORMAL) ||
                    (trx_r == lin_wake_pkg::TRX_RXONLY);
  wire trx_wr_ok  = commit && (dev_r != lin_wake_pkg::DEV_FAILSAFE);
  wire dev_wr_ok  = commit && dev_mode_wr_in;
  wire dev_change = (dev_nxt != dev_r);
  wire rearm_dev  = dev_change && ((dev_nxt == lin_wake_pkg::DEV_STOP) ||
                    (dev_nxt == lin_wake_pkg::DEV_SLEEP) ||
                    (dev_nxt == lin_wake_pkg::DEV_FAILSAFE));
  wire wake_sleep = wake && ((dev_r == lin_wake_pkg::DEV_SLEEP) ||
                    (dev_r == lin_wake_pkg::DEV_FAILSAFE));
  wire tx_to_hit  = (tx_cnt_r >= lin_wake_pkg::TIMER_W'(TX_TO_CYC));
  wire bus_to_hit = (bus_cnt_r >= lin_wake_pkg::TIMER_W'(BUS_TO_CYC));

  lin_wake_filter u_filter (
    .clock_in        (clock_in),
    .rst_n_in        (rst_n_in),
    .clk_en_in       (clk_en_in),
    .armed_in        (armed_r && wake_mode),
    .bus_dominant_in (bus_dom),
    .wake_pulse_out  (wake)
  );

  // Device mode next state
  always_comb begin
    dev_nxt = dev_r;
    case (dev_r)
      lin_wake_pkg::DEV_SLEEP,
      lin_wake_pkg::DEV_FAILSAFE: begin
        if (wake_sleep) dev_nxt = lin_wake_pkg::DEV_RESTART;
      end
      lin_wake_pkg::DEV_RESTART: begin
        if (restart_done_in) dev_nxt = lin_wake_pkg::DEV_NORMAL;
      end
      default: begin
        if (dev_wr_ok) dev_nxt = lin_wake_pkg::dev_mode_t'(dev_mode_in);
      end
    endcase
    if (dev_wr_ok && dev_r != lin_wake_pkg::DEV_FAILSAFE && !wake_sleep) begin
      dev_nxt = lin_wake_pkg::dev_mode_t'(dev_mode_in);
    end
    if (fail_safe_in) dev_nxt = lin_wake_pkg::DEV_FAILSAFE;
  end

  // Transceiver mode next value
  always_comb begin
    trx_nxt = trx_r;
    if (trx_wr_ok) trx_nxt = trx_mode_in;
    if (dev_nxt == lin_wake_pkg::DEV_FAILSAFE) trx_nxt = lin_wake_pkg::TRX_WAKE;
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      cs_prev_r <= 1'b1;
      dev_r     <= lin_wake_pkg::DEV_NORMAL;
      trx_r     <= lin_wake_pkg::TRX_RESET;
      armed_r   <= 1'b1;
      woken_r   <= 1'b0;
    end else if (clk_en_in) begin
      cs_prev_r <= cs_n_s;
      dev_r     <= dev_nxt;
      trx_r     <= trx_nxt;
      if (wake) begin
        armed_r <= 1'b0;
        woken_r <= 1'b1;
      end else if (trx_nxt != lin_wake_pkg::TRX_WAKE || rearm_dev) begin
        armed_r <= 1'b1;
        woken_r <= (trx_nxt == lin_wake_pkg::TRX_WAKE) && woken_r;
      end
    end
  end

  // Wake reporting, watchdog, slope
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      int_r   <= 1'b0;
      wkst_r  <= 1'b0;
      wdg_r   <= 1'b0;
      lsm_r   <= 1'b0;
      flash_r <= 1'b0;
    end else if (clk_en_in) begin
      int_r  <= (wake && (in_stop || in_normal)) || (int_r && !interrupt_clear_in);
      wkst_r <= wake || (wkst_r && !wake_status_clear_in);
      if (wake && in_stop && watchdog_on_bus_wake_en_in) begin
        wdg_r <= 1'b1;
      end else if (commit) begin
        wdg_r <= watchdog_en_in;
      end
      if (commit && in_normal) begin
        lsm_r   <= low_slope_select_in;
        flash_r <= flash_speed_in;
      end
    end
  end

  // Dominant timers and fault flag
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      tx_cnt_r   <= '0;
      bus_cnt_r  <= '0;
      tx_block_r <= 1'b0;
      fault_r    <= 1'b0;
    end else if (clk_en_in) begin
      if (!tx_dom) begin
        tx_cnt_r   <= '0;
        tx_block_r <= 1'b0;
      end else if (!tx_to_hit) begin
        tx_cnt_r <= tx_cnt_r + 1'b1;
      end else begin
        tx_block_r <= 1'b1;
      end
      if (!bus_dom || !trx_active) begin
        bus_cnt_r <= '0;
      end else if (!bus_to_hit) begin
        bus_cnt_r <= bus_cnt_r + 1'b1;
      end
      fault_r <= (tx_dom && tx_to_hit) || (bus_dom && trx_active && bus_to_hit) ||
                 (fault_r && !fault_clear_in);
    end
  end

  // Registered outputs
  wire drv_en = (trx_r == lin_wake_pkg::TRX_NORMAL) && !uv && !tx_block_r;
  wire rx_en  = trx_active && !uv;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      bus_receive_out     <= 1'b1;
      bus_drive_dom_out   <= 1'b0;
      driver_en_out       <= 1'b0;
      receiver_en_out     <= 1'b0;
      interrupt_out_n     <= 1'b1;
      wake_status_reg_out <= 1'b0;
      fault_flag_out      <= 1'b0;
      watchdog_en_out     <= 1'b0;
      low_slope_out       <= 1'b0;
      flash_speed_out     <= 1'b0;
      trx_mode_out        <= lin_wake_pkg::TRX_RESET;
      dev_mode_out        <= 3'h0;
    end else if (clk_en_in) begin
      bus_receive_out     <= !woken_r && !(rx_en && bus_dom);
      bus_drive_dom_out   <= drv_en && tx_dom;
      driver_en_out       <= drv_en;
      receiver_en_out     <= rx_en;
      interrupt_out_n     <= !int_r;
      wake_status_reg_out <= wkst_r;
      fault_flag_out      <= fault_r;
      watchdog_en_out     <= wdg_r;
      low_slope_out       <= lsm_r && !flash_r;
      flash_speed_out     <= flash_r;
      trx_mode_out        <= trx_r;
      dev_mode_out        <= dev_r;
    end
  end

  // Checks
  a_wake_rx_low: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && wake ##1 (clk_en_in && !commit) [*2] |=> !bus_receive_out)
    else $error("Receive output not low after wake");
  a_wake_int: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && wake && in_stop ##1 (clk_en_in && !interrupt_clear_in) [*2]
    |=> !interrupt_out_n)
    else $error("Interrupt missing after stop wake");
  a_sleep_restart: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && wake_sleep && !fail_safe_in
    |=> dev_r == lin_wake_pkg::DEV_RESTART && (!int_r || $past(int_r)))
    else $error("Sleep wake did not enter restart");
  a_wake_keeps: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && wake && !commit && !fail_safe_in |=> trx_r == lin_wake_pkg::TRX_WAKE)
    else $error("Mode field changed on wake");
  a_rearm_dev: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && rearm_dev && !wake |=> armed_r)
    else $error("Wake not rearmed on mode change");
  a_wdg_wake: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && wake && in_stop && watchdog_on_bus_wake_en_in ##1 clk_en_in |=> watchdog_en_out)
    else $error("Watchdog not enabled on wake");
  a_tx_block: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && tx_block_r |=> !driver_en_out && !bus_drive_dom_out)
    else $error("Driver enabled while blocked");
  a_tx_fault: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && tx_dom && tx_to_hit |=> fault_r)
    else $error("Fault not set on transmit timeout");
  a_tx_recover: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && !tx_dom |=> !tx_block_r)
    else $error("Driver not recovered");
  a_fault_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && fault_r && !fault_clear_in |=> fault_r)
    else $error("Fault flag lost");
  a_uv_off: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && uv |=> !driver_en_out && !receiver_en_out)
    else $error("Stages on under undervoltage");
  a_slope_gate: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_en_in && !(commit && in_normal) |=> $stable(lsm_r))
    else $error("Slope changed outside commit");

  c_stop_wake:  cover property (@(posedge clock_in) wake && in_stop);
  c_sleep_wake: cover property (@(posedge clock_in) wake_sleep);
  c_tx_timeout: cover property (@(posedge clock_in) $rose(tx_block_r));
  c_bus_clamp:  cover property (@(posedge clock_in) bus_to_hit && trx_active);

endmodule

// ==== verif/lin_bus_node_model.sv ====
/*
  Far side of the single-wire bus: the bus nodes and the line pull-up.
  Assumes the device drives dominant only while its driver is enabled.
*/
`timescale 1ns/100ps
module lin_bus_node_model (
  // Device side
  input  wire logic drive_dom_in,
  input  wire logic driver_en_in,
  // Remote node
  input  wire logic remote_dom_in,
  // Wire
  output logic      bus_level_out
);
  // Wired-and with pull-up: a released line reads recessive
  assign bus_level_out = ~((drive_dom_in & driver_en_in) | remote_dom_in);
endmodule

// ==== verif/lin_wake_fault_mode_control_tb_top.sv ====
/*
  Self-checking bench for the wake, fault and mode control.
  Assumes a 40 MHz clock and shortened dominant timeouts of 50 cycles.
*/
`timescale 1ns/100ps
module lin_wake_fault_mode_control_tb_top;
  logic       clock_in, rst_n_in, cs_n, dev_wr, ls, fl, wow, wde;
  logic       f_clr, s_clr, i_clr, fs, rdone, txd, uv, rdom, lvl;
  logic [1:0] trx;
  logic [2:0] dev;
  logic       rx, ddom, den, ren, int_n, wst, flt, wdo, lso, flo;
  logic [1:0] trx_o;
  logic [2:0] dev_o;
  int         n_fail, samples_checked;

  lin_wake_ctrl #(.TX_TO_CYC(50), .BUS_TO_CYC(50)) dut_u (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1),
    .chip_select_n_in(cs_n), .trx_mode_in(trx), .dev_mode_in(dev),
    .dev_mode_wr_in(dev_wr), .low_slope_select_in(ls), .flash_speed_in(fl),
    .watchdog_on_bus_wake_en_in(wow), .watchdog_en_in(wde), .fault_clear_in(f_clr),
    .wake_status_clear_in(s_clr), .interrupt_clear_in(i_clr), .fail_safe_in(fs),
    .restart_done_in(rdone), .bus_transmit_in(txd), .bus_level_in(lvl),
    .bus_supply_uv_in(uv), .bus_receive_out(rx), .bus_drive_dom_out(ddom),
    .driver_en_out(den), .receiver_en_out(ren), .interrupt_out_n(int_n),
    .wake_status_reg_out(wst), .fault_flag_out(flt), .watchdog_en_out(wdo),
    .low_slope_out(lso), .flash_speed_out(flo), .trx_mode_out(trx_o),
    .dev_mode_out(dev_o));

  lin_bus_node_model bus_u (.drive_dom_in(ddom), .driver_en_in(den),
    .remote_dom_in(rdom), .bus_level_out(lvl));

  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  task automatic end_sim();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock_in);
  endtask

  // Configuration word committed at chip select release
  task automatic cfg(input logic [1:0] t, input logic [2:0] d, input logic l, input logic f);
    cyc(1);
    trx = t;
    dev = d;
    ls = l;
    fl = f;
    cs_n = 1'b0;
    cyc(4);
    cs_n = 1'b1;
    cyc(10);
  endtask

  // Remote node holds the bus dominant for n cycles
  task automatic dom(input int n);
    rdom = 1'b1;
    cyc(n);
    rdom = 1'b0;
    cyc(8);
  endtask

  task automatic clr();
    i_clr = 1'b1;
    s_clr = 1'b1;
    cyc(1);
    i_clr = 1'b0;
    s_clr = 1'b0;
    cyc(3);
  endtask

  initial begin
    {cs_n, txd} = 2'h3;
    {dev_wr, ls, fl, wow, wde, f_clr, s_clr, i_clr, fs, rdone, uv, rdom} = 12'h800;
    trx = 2'h0;
    dev = 3'h0;
    n_fail = 0;
    samples_checked = 0;
    rst_n_in = 1'b0;
    cyc(10);
    rst_n_in = 1'b1;
    cyc(6);
    chk({int_n, flt, lso}, 3'h4);
    chk({trx_o, flo}, 3'h0);
    chk(dev_o, 3'h0);
    cfg(2'h3, 3'h0, 1'b1, 1'b0);
    chk({lso, flo}, 3'h2);
    cfg(2'h3, 3'h0, 1'b0, 1'b1);
    chk({lso, flo}, 3'h1);
    cfg(2'h3, 3'h0, 1'b0, 1'b0);
    // Transmit stuck dominant
    chk(den, 3'h1);
    txd = 1'b0;
    cyc(45);
    chk({den, ddom}, 3'h3);
    for (int i = 0; i < 40 && den !== 1'b0; i++) cyc(1);
    if (den !== 1'b0) begin
      n_fail++;
      $display("MISMATCH t=%0t driver not disabled on transmit timeout", $time);
      end_sim();
    end
    cyc(2);
    chk({flt, lvl}, 3'h3);
    chk(trx_o, 3'h3);
    txd = 1'b1;
    cyc(8);
    chk({den, flt}, 3'h3);
    f_clr = 1'b1;
    cyc(1);
    f_clr = 1'b0;
    cyc(3);
    chk(flt, 3'h0);
    // Bus clamped dominant
    dom(40);
    chk(flt, 3'h0);
    dom(60);
    chk(flt, 3'h1);
    f_clr = 1'b1;
    cyc(1);
    f_clr = 1'b0;
    // Supply undervoltage
    uv = 1'b1;
    cyc(8);
    chk({den, ren}, 3'h0);
    uv = 1'b0;
    cyc(8);
    chk({den, ren}, 3'h3);
    chk(trx_o, 3'h3);
    // Wake in normal device mode
    cfg(2'h1, 3'h0, 1'b0, 1'b0);
    dom(1000);
    chk({int_n, rx}, 3'h3);
    dom(1400);
    chk({int_n, rx, wst}, 3'h1);
    chk({trx_o, dev_o[0]}, 3'h2);
    clr();
    dom(1400);
    chk({int_n, rx}, 3'h2);
    cfg(2'h3, 3'h0, 1'b0, 1'b0);
    chk(rx, 3'h1);
    cfg(2'h1, 3'h0, 1'b0, 1'b0);
    dom(1400);
    chk(int_n, 3'h0);
    // Wake in stop mode enables the watchdog
    clr();
    wow = 1'b1;
    dev_wr = 1'b1;
    cfg(2'h1, 3'h1, 1'b0, 1'b0);
    chk(wdo, 3'h0);
    dom(1400);
    chk({int_n, wdo}, 3'h1);
    chk(dev_o, 3'h1);
    // Wake from sleep, then from fail-safe
    for (int i = 0; i < 2; i++) begin
      clr();
      if (i == 0) begin
        cfg(2'h1, 3'h3, 1'b0, 1'b0);
      end else begin
        fs = 1'b1;
        cyc(1);
        fs = 1'b0;
        cyc(8);
        chk({trx_o, dev_o[1]}, 3'h3);
      end
      dom(1400);
      chk(dev_o, 3'h6);
      chk({int_n, rx, wst}, 3'h5);
      rdone = 1'b1;
      cyc(1);
      rdone = 1'b0;
      cyc(4);
      chk(dev_o, 3'h0);
    end
    end_sim();
  end
endmodule
